// [common/pdtc_pkg.sv]
`default_nettype none
package pdtc_pkg;
    // Widths of the memory side
    localparam int ROW_W   = 13;
    localparam int COL_W   = 10;
    localparam int DATA_W  = 32;
    localparam int BEATS_W = 6;
    localparam int T_W     = 7;
    localparam int LAT_W   = 2;

    // Read data buffer and SDRAM timing
    localparam int FIFO_DEPTH  = 32;
    localparam int CAS_LATENCY = 3;
    localparam int SYNC_STAGES = 3;

    // SDRAM commands as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_DESEL = 4'hf;
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_PRE   = 4'h2;

    // Reset and idle levels of the transfer pins
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic ACCESS_IDLE = 1'b1;
    localparam logic WAY_IDLE    = 1'b1;

    typedef enum logic [1:0] {
        PDTC_IDLE  = 2'b00,
        PDTC_PRECH = 2'b01,
        PDTC_ROW_ACTIVATE_CMD  = 2'b10,
        PDTC_DATA  = 2'b11
    } pdtc_state_type;
endpackage : pdtc_pkg
`default_nettype wire

// [hw/pdtc_edge_sync.sv]
`default_nettype none
module pdtc_edge_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Level from another domain
    input  wire logic level_in,
    // One-cycle pulse on a settled rising edge
    output logic      rise
);
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;

    // A change counts only once stages two and three agree
    always_ff @(posedge clock) begin
        if (rst) begin
            ff1   <= 1'b0;
            ff2   <= 1'b0;
            ff3   <= 1'b0;
            level <= 1'b0;
        end else begin
            ff1 <= level_in;
            ff2 <= ff1;
            ff3 <= ff2;
            if (ff2 == ff3) begin
                level <= ff3;
            end
        end
    end

    assign rise = ff2 & ff3 & ~level;
endmodule : pdtc_edge_sync
`default_nettype wire

// [hw/pdtc_fifo.sv]
`default_nettype none
module pdtc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // Filling side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // Draining side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    localparam logic [LW-1:0] FULL = LW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (level != FULL);
    assign out_valid = (level != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                level <= level + 1'b1;
            end else if (pop && !push) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule : pdtc_fifo
`default_nettype wire

// [hw/pdtc_transfer_ctl.sv]
`default_nettype none
module pdtc_transfer_ctl #(
    parameter int CAS_LATENCY = pdtc_pkg::CAS_LATENCY,
    parameter int FIFO_DEPTH  = pdtc_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Memory clock as seen on the board
    input  wire logic                          memory_clock_out,
    // Strobe latency settings
    input  wire logic [pdtc_pkg::LAT_W-1:0]    write_strobe_latency,
    input  wire logic [pdtc_pkg::LAT_W-1:0]    read_strobe_latency,
    // Transfer request
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic                          source_periph_flag,
    input  wire logic                          dest_periph_flag,
    input  wire logic                          req_write,
    input  wire logic [pdtc_pkg::ROW_W-1:0]    req_row,
    input  wire logic [pdtc_pkg::COL_W-1:0]    req_col,
    input  wire logic [pdtc_pkg::BEATS_W-1:0]  req_beats,
    // Ordinary write data
    input  wire logic [pdtc_pkg::DATA_W-1:0]   wr_data,
    output logic                               wr_data_take,
    // Ordinary read data
    output logic                               rd_valid,
    input  wire logic                          rd_ready,
    output logic [pdtc_pkg::DATA_W-1:0]        rd_data,
    // SDRAM pins
    output logic                               chip_space_select_n,
    output logic                               ras_n,
    output logic                               cas_n,
    output logic                               we_n,
    output logic [pdtc_pkg::ROW_W-1:0]         sdram_addr,
    output logic [pdtc_pkg::DATA_W-1:0]        ext_data_bus_out,
    output logic                               ext_data_bus_oe,
    input  wire logic [pdtc_pkg::DATA_W-1:0]   ext_data_bus_in,
    // Peripheral transfer pins
    output logic                               periph_xfer_strobe_n,
    output logic                               periph_xfer_access_pin,
    output logic                               periph_xfer_way_pin,
    // Status
    output logic                               busy
);
    localparam int T_W = pdtc_pkg::T_W;
    localparam int LW  = $clog2(FIFO_DEPTH+1);
    localparam logic [T_W-1:0] CL_T    = T_W'(CAS_LATENCY);
    localparam logic [LW-1:0]  DEPTH_L = LW'(FIFO_DEPTH);

    function automatic logic in_window(input logic [T_W-1:0] t,
                                       input logic [T_W-1:0] start,
                                       input logic [T_W-1:0] len);
        in_window = (t >= start) && (t < start + len);
    endfunction

    pdtc_pkg::pdtc_state_type state;
    pdtc_pkg::pdtc_state_type next_state;

    logic [T_W-1:0]                 t;
    logic                           cur_pdt;
    logic                           cur_rd;
    logic [pdtc_pkg::ROW_W-1:0]     cur_row;
    logic [pdtc_pkg::COL_W-1:0]     cur_col;
    logic [pdtc_pkg::BEATS_W-1:0]   cur_beats;
    logic [pdtc_pkg::LAT_W-1:0]     cur_wl;
    logic [pdtc_pkg::LAT_W-1:0]     cur_rl;
    logic                           page_open;
    logic                           page_pdt;
    logic [pdtc_pkg::ROW_W-1:0]     page_row;
    logic [3:0]                     cmd;
    logic [pdtc_pkg::DATA_W-1:0]    din_d1;
    logic [pdtc_pkg::DATA_W-1:0]    din_d2;
    logic [pdtc_pkg::DATA_W-1:0]    din_d3;
    logic [LW-1:0]                  fifo_level;
    logic                           fifo_in_ready;
    logic                           mrise;

    logic [3:0]                     next_cmd;
    logic [pdtc_pkg::ROW_W-1:0]     next_addr;
    logic                           next_strobe_n;
    logic                           next_access;
    logic                           next_way;
    logic                           next_oe;

    // Edges of the memory clock pace every pin change
    pdtc_edge_sync u_mclk_sync (
        .clock    (clock),
        .rst      (rst),
        .level_in (memory_clock_out),
        .rise     (mrise)
    );

    // Request decode
    wire want_pdt = source_periph_flag | dest_periph_flag;
    wire want_rd  = source_periph_flag | (~dest_periph_flag & ~req_write);
    wire page_hit = page_open && (page_row == req_row);
    wire [LW-1:0] fifo_free = DEPTH_L - fifo_level;
    // Ordinary reads wait for room for the whole burst, so captures never overflow
    wire fifo_room = want_pdt | ~want_rd | (fifo_free >= LW'(req_beats));
    wire accept    = req_valid & req_ready;
    assign req_ready = (state == pdtc_pkg::PDTC_IDLE) & fifo_room;
    assign busy      = (state != pdtc_pkg::PDTC_IDLE);

    // Data phase timing
    wire [T_W-1:0] beats_t = T_W'(cur_beats);
    wire [T_W-1:0] wl_t    = T_W'(cur_wl);
    wire [T_W-1:0] rl_t    = T_W'(cur_rl);
    wire [T_W-1:0] lead    = (CL_T >= rl_t) ? CL_T - rl_t : '0;
    wire [T_W-1:0] cap_at  = CL_T + 7'd1;
    wire [T_W-1:0] t_end   = cur_rd ? cap_at + beats_t : wl_t + beats_t;
    wire in_data  = (state == pdtc_pkg::PDTC_DATA);
    wire last_t   = in_data && (t == t_end);
    wire rd_cmd   = in_data && cur_rd && in_window(t, '0, beats_t);
    wire wr_cmd   = in_data && !cur_rd && in_window(t, wl_t, beats_t);
    wire strobe_on = in_data && cur_pdt &&
                     (cur_rd ? in_window(t, lead, beats_t)
                             : in_window(t, '0, beats_t));
    wire [T_W-1:0] col_off = cur_rd ? t : t - wl_t;
    wire [pdtc_pkg::COL_W-1:0] col_now = cur_col + pdtc_pkg::COL_W'(col_off);
    // Transfer reads never capture the bus
    wire capture = mrise && cur_rd && !cur_pdt && in_data &&
                   in_window(t, cap_at, beats_t);
    assign wr_data_take = mrise && wr_cmd && !cur_pdt;

    always_comb begin
        next_state    = state;
        next_cmd      = pdtc_pkg::CMD_NOP;
        next_addr     = sdram_addr;
        next_strobe_n = pdtc_pkg::STROBE_IDLE;
        next_access   = pdtc_pkg::ACCESS_IDLE;
        next_way      = pdtc_pkg::WAY_IDLE;
        next_oe       = 1'b0;
        case (state)
            pdtc_pkg::PDTC_IDLE: begin
                next_cmd = pdtc_pkg::CMD_DESEL;
                if (accept) begin
                    if (page_hit && (page_pdt || !want_pdt)) begin
                        next_state = pdtc_pkg::PDTC_DATA;
                    end else if (page_open) begin
                        next_state = pdtc_pkg::PDTC_PRECH;
                    end else begin
                        next_state = pdtc_pkg::PDTC_ROW_ACTIVATE_CMD;
                    end
                end
            end
            pdtc_pkg::PDTC_PRECH: begin
                next_cmd   = pdtc_pkg::CMD_PRE;
                next_state = pdtc_pkg::PDTC_ROW_ACTIVATE_CMD;
            end
            pdtc_pkg::PDTC_ROW_ACTIVATE_CMD: begin
                next_cmd    = pdtc_pkg::CMD_ACT;
                next_addr   = cur_row;
                next_access = !cur_pdt;
                next_way    = !(cur_pdt && !cur_rd);
                next_state  = pdtc_pkg::PDTC_DATA;
            end
            pdtc_pkg::PDTC_DATA: begin
                if (last_t) begin
                    next_state = pdtc_pkg::PDTC_IDLE;
                end else begin
                    next_access   = !cur_pdt;
                    next_way      = !(cur_pdt && !cur_rd);
                    next_strobe_n = !strobe_on;
                    next_oe       = wr_cmd && !cur_pdt;
                    if (rd_cmd) begin
                        next_cmd = pdtc_pkg::CMD_READ;
                    end else if (wr_cmd) begin
                        next_cmd = pdtc_pkg::CMD_WRITE;
                    end
                    if (rd_cmd || wr_cmd) begin
                        next_addr = {{(pdtc_pkg::ROW_W-pdtc_pkg::COL_W){1'b0}}, col_now};
                    end
                end
            end
            default: begin
                next_state = pdtc_pkg::PDTC_IDLE;
            end
        endcase
    end

    // Requests are taken on any clock, commands advance on memory clock edges
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= pdtc_pkg::PDTC_IDLE;
        end else if (accept || (mrise && state != pdtc_pkg::PDTC_IDLE)) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cur_pdt   <= 1'b0;
            cur_rd    <= 1'b0;
            cur_row   <= '0;
            cur_col   <= '0;
            cur_beats <= '0;
            cur_wl    <= '0;
            cur_rl    <= '0;
        end else if (accept) begin
            cur_pdt   <= want_pdt;
            cur_rd    <= want_rd;
            cur_row   <= req_row;
            cur_col   <= req_col;
            cur_beats <= req_beats;
            cur_wl    <= write_strobe_latency;
            cur_rl    <= read_strobe_latency;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            t <= '0;
        end else if (accept || (mrise && state == pdtc_pkg::PDTC_ROW_ACTIVATE_CMD)) begin
            t <= '0;
        end else if (mrise && in_data) begin
            t <= t + 7'd1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            page_open <= 1'b0;
            page_pdt  <= 1'b0;
            page_row  <= '0;
        end else if (mrise && state == pdtc_pkg::PDTC_PRECH) begin
            page_open <= 1'b0;
        end else if (mrise && state == pdtc_pkg::PDTC_ROW_ACTIVATE_CMD) begin
            page_open <= 1'b1;
            page_pdt  <= cur_pdt;
            page_row  <= cur_row;
        end else if (accept && page_hit) begin
            // The latest access decides whether a transfer may reuse the page
            page_pdt  <= want_pdt;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cmd                    <= pdtc_pkg::CMD_DESEL;
            sdram_addr             <= '0;
            periph_xfer_strobe_n   <= pdtc_pkg::STROBE_IDLE;
            periph_xfer_access_pin <= pdtc_pkg::ACCESS_IDLE;
            periph_xfer_way_pin    <= pdtc_pkg::WAY_IDLE;
            ext_data_bus_oe        <= 1'b0;
            ext_data_bus_out       <= '0;
        end else if (mrise) begin
            cmd                    <= next_cmd;
            sdram_addr             <= next_addr;
            periph_xfer_strobe_n   <= next_strobe_n;
            periph_xfer_access_pin <= next_access;
            periph_xfer_way_pin    <= next_way;
            ext_data_bus_oe        <= next_oe;
            if (wr_data_take) begin
                ext_data_bus_out <= wr_data;
            end
        end
    end

    assign {chip_space_select_n, ras_n, cas_n, we_n} = cmd;

    // Delay matches the memory clock synchroniser so captures line up with edges
    always_ff @(posedge clock) begin
        if (rst) begin
            din_d1 <= '0;
            din_d2 <= '0;
            din_d3 <= '0;
        end else begin
            din_d1 <= ext_data_bus_in;
            din_d2 <= din_d1;
            din_d3 <= din_d2;
        end
    end

    pdtc_fifo #(
        .WIDTH (pdtc_pkg::DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rd_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (capture),
        .in_ready  (fifo_in_ready),
        .in_data   (din_d3),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data),
        .level     (fifo_level)
    );

    property p_strobe_needs_access;
        @(posedge clock) disable iff (rst)
        !periph_xfer_strobe_n |-> !periph_xfer_access_pin;
    endproperty
    a_strobe_needs_access: assert property (p_strobe_needs_access)
        else $error("strobe active without access pin");

    property p_read_way_high;
        @(posedge clock) disable iff (rst)
        (busy && cur_pdt && cur_rd) |-> periph_xfer_way_pin;
    endproperty
    a_read_way_high: assert property (p_read_way_high)
        else $error("way pin low during transfer read");

    property p_no_drive_in_pdt;
        @(posedge clock) disable iff (rst)
        (busy && cur_pdt) |-> !ext_data_bus_oe;
    endproperty
    a_no_drive_in_pdt: assert property (p_no_drive_in_pdt)
        else $error("data bus driven during transfer");

    property p_no_capture_pdt;
        @(posedge clock) disable iff (rst)
        (busy && cur_pdt && cur_rd) |=> (fifo_level <= $past(fifo_level));
    endproperty
    a_no_capture_pdt: assert property (p_no_capture_pdt)
        else $error("transfer read data captured");

    property p_act_access;
        @(posedge clock) disable iff (rst)
        ($changed(cmd) && cmd == pdtc_pkg::CMD_ACT && cur_pdt) |->
            !periph_xfer_access_pin && (periph_xfer_way_pin == cur_rd);
    endproperty
    a_act_access: assert property (p_act_access)
        else $error("access or way pin wrong at activate");

    property p_hit_skips_act;
        @(posedge clock) disable iff (rst)
        (accept && want_pdt && page_hit && page_pdt) |=> (state == pdtc_pkg::PDTC_DATA);
    endproperty
    a_hit_skips_act: assert property (p_hit_skips_act)
        else $error("open transfer page not used directly");

    property p_reopen;
        @(posedge clock) disable iff (rst)
        (accept && want_pdt && page_open && !page_pdt) |=> (state == pdtc_pkg::PDTC_PRECH);
    endproperty
    a_reopen: assert property (p_reopen)
        else $error("ordinary page not closed for transfer");

    property p_end_release;
        @(posedge clock) disable iff (rst)
        (mrise && last_t) |=> periph_xfer_strobe_n && periph_xfer_access_pin && !busy;
    endproperty
    a_end_release: assert property (p_end_release)
        else $error("pins not released after last beat");

    property p_read_lead;
        @(posedge clock) disable iff (rst)
        ($fell(periph_xfer_strobe_n) && cur_rd) |-> (t == lead + 7'd1);
    endproperty
    a_read_lead: assert property (p_read_lead)
        else $error("read strobe lead wrong");

    property p_source_flag;
        @(posedge clock) disable iff (rst)
        (accept && source_periph_flag) |=> (cur_pdt && cur_rd);
    endproperty
    a_source_flag: assert property (p_source_flag)
        else $error("source flag did not select transfer read");

    property p_read_cmds;
        @(posedge clock) disable iff (rst)
        (busy && cur_pdt && cur_rd) |-> (cmd != pdtc_pkg::CMD_WRITE);
    endproperty
    a_read_cmds: assert property (p_read_cmds)
        else $error("write command during transfer read");
endmodule : pdtc_transfer_ctl
`default_nettype wire

// [tb/pdtc_far_model.sv]
`default_nettype none
// SDRAM data lines plus the two-FIFO glue; glue lets any strobe latency work
// Only SDRAM shares this bus, so the strobe alone may serve as a FIFO enable
module pdtc_far_model (
    // Board memory clock and chip select
    input  wire logic                   memory_clock_out,
    input  wire logic                   chip_space_select_n,
    // Transfer pins
    input  wire logic                   periph_xfer_strobe_n,
    input  wire logic                   periph_xfer_way_pin,
    // Shared data bus as the controller sees it
    output logic [pdtc_pkg::DATA_W-1:0] ext_data_bus_in,
    // Enables counted at the two FIFOs
    output int                          fifo_write_count,
    output int                          fifo_read_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dir_latched = 1'b1;
    // Transparent while selected, so a page hit sees the new way at once
    wire  dir_now = (chip_space_select_n === 1'b0) ? periph_xfer_way_pin : dir_latched;
    initial begin
        ext_data_bus_in = 32'h0000_0000;
        fifo_write_count = 0;
        fifo_read_count = 0;
    end
    always @(posedge memory_clock_out) begin
        // Bus never holds a value, so stale data cannot pass as good
        ext_data_bus_in <= ext_data_bus_in + 32'h1357_9bdf;
        if (chip_space_select_n === 1'b0) dir_latched <= periph_xfer_way_pin;
        if (periph_xfer_strobe_n === 1'b0) begin
            if (dir_now) fifo_write_count <= fifo_write_count + 1;
            else fifo_read_count <= fifo_read_count + 1;
        end
    end
endmodule // pdtc_far_model
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, mclk = 0, req_valid = 0, src = 0, dst = 0, req_write = 0, rd_ready = 0;
    logic [1:0] wl = 0, rl = 0;
    logic [pdtc_pkg::ROW_W-1:0] row = 0, addr;
    logic [pdtc_pkg::BEATS_W-1:0] beats = 1;
    logic [pdtc_pkg::DATA_W-1:0] wr_data = 0, bus_in, dout, rdata, exp_q[$];
    logic req_ready, rd_valid, cs_n, ras_n, cas_n, we_n, oe, stb_n, acc, way, busy;
    int mismatches = 0, num_checks = 0, fw, fr;
    int e, n_act, n_pre, n_rd, n_wr, n_stb, n_oe, f_rd, f_wr, f_stb, way_low, act_ok, bad_pins;
    int open_row = -1, open_xfer = 0;
    int fix_wl = -1, fix_rl = -1;
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    logic [3:0] rd_pipe = 0;
    initial forever #5 clock = ~clock;
    initial forever #80 mclk = ~mclk;
    pdtc_transfer_ctl pdtc_transfer_ctl_i (.clock(clock), .rst(rst), .memory_clock_out(mclk),
        .write_strobe_latency(wl), .read_strobe_latency(rl), .req_valid(req_valid),
        .req_ready(req_ready), .source_periph_flag(src), .dest_periph_flag(dst),
        .req_write(req_write), .req_row(row), .req_col(10'h005), .req_beats(beats),
        .wr_data(wr_data), .wr_data_take(), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rdata), .chip_space_select_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .sdram_addr(addr), .ext_data_bus_out(dout), .ext_data_bus_oe(oe), .ext_data_bus_in(bus_in),
        .periph_xfer_strobe_n(stb_n), .periph_xfer_access_pin(acc),
        .periph_xfer_way_pin(way), .busy(busy));
    pdtc_far_model pdtc_far_model_i (.memory_clock_out(mclk), .chip_space_select_n(cs_n),
        .periph_xfer_strobe_n(stb_n), .periph_xfer_way_pin(way), .ext_data_bus_in(bus_in),
        .fifo_write_count(fw), .fifo_read_count(fr));
    // Pins settle a few clocks after each memory rise; mid-period is safe to look
    always @(negedge mclk) if (busy === 1'b1) begin
        e++;
        if (cmd === pdtc_pkg::CMD_ACT) begin n_act++; act_ok = (acc === 1'b0 && way === src); end
        if (cmd === pdtc_pkg::CMD_ACT && addr !== row) bad_pins++;
        if (cmd === pdtc_pkg::CMD_PRE) n_pre++;
        if (cmd === pdtc_pkg::CMD_READ) begin n_rd++; if (f_rd < 0) f_rd = e; end
        if (cmd === pdtc_pkg::CMD_READ && addr !== 13'(4 + n_rd)) bad_pins++;
        if (cmd === pdtc_pkg::CMD_WRITE) begin n_wr++; if (f_wr < 0) f_wr = e; end
        if (cmd === pdtc_pkg::CMD_WRITE && addr !== 13'(4 + n_wr)) bad_pins++;
        if (stb_n === 1'b0) begin n_stb++; if (f_stb < 0) f_stb = e; end
        if (oe === 1'b1) n_oe++;
        if (oe === 1'b1 && dout !== wr_data) bad_pins++;
        if (way === 1'b0) way_low++;
        // Memory data arrives CL+1 edges after its read command
        if (rd_pipe[3] && !src && !dst) exp_q.push_back(bus_in);
        rd_pipe = {rd_pipe[2:0], cmd === pdtc_pkg::CMD_READ};
    end
    task automatic chk(input bit ok, input string m);
        num_checks++;
        if (!ok) begin mismatches++; $display("BAD %0t %s", $time, m); end
    endtask
    task automatic print_verdict;
        $display("mismatches %0d num_checks %0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic drain(output int n);
        n = 0;
        @(posedge clock);
        rd_ready <= 1;
        repeat (40) begin
            @(negedge clock);
            if (rd_valid === 1'b1) begin
                n++;
                chk(exp_q.size() > 0 && rdata === exp_q.pop_front(), "read data");
            end
        end
        @(posedge clock);
        rd_ready <= 0;
        chk(exp_q.size() == 0, "read words missing");
    endtask
    task automatic run(input bit s, input bit d, input bit w, input int r, input int b);
        int xfer, hit, fw0, fr0, n;
        drain(n);
        @(posedge clock);
        src <= s; dst <= d; req_write <= w; row <= r; beats <= b; req_valid <= 1;
        wl <= (fix_wl < 0) ? 2'($urandom % 4) : 2'(fix_wl);
        rl <= (fix_rl < 0) ? 2'($urandom % 4) : 2'(fix_rl);
        wr_data <= $urandom;
        do @(negedge clock); while (req_ready !== 1'b1);
        @(posedge clock);
        req_valid <= 0;
        {e, n_act, n_pre, n_rd, n_wr, n_stb, n_oe, way_low, act_ok, bad_pins} = '0;
        {f_rd, f_wr, f_stb} = '1;
        fw0 = fw; fr0 = fr; n = 0;
        do begin @(negedge clock); n++; end while (busy === 1'b1 && n < 4000);
        chk(n < 4000, "transfer did not finish");
        chk(bad_pins == 0, "address or data pin wrong");
        xfer = s | d;
        hit = (open_row == r) && (open_xfer || !xfer);
        chk(n_act == !hit && (hit || act_ok || !xfer), "activate");
        chk(n_pre == (open_row >= 0 && !hit), "precharge");
        chk(stb_n === 1'b1 && acc === 1'b1 && way === 1'b1, "pins idle");
        if (s) begin
            chk(n_rd == b && n_stb == b && way_low == 0 && n_oe == 0, "pdt read");
            chk(f_stb - f_rd == pdtc_pkg::CAS_LATENCY - int'(rl), "read lead");
            chk(fw - fw0 == b && rd_valid === 1'b0, "fifo write");
        end else if (d) begin
            chk(n_wr == b && n_stb == b && n_oe == 0, "pdt write");
            chk(f_wr - f_stb == wl && fr - fr0 == b, "write lead");
        end else if (w) chk(n_wr == b && n_oe == b && n_stb == 0, "plain write");
        else chk(n_rd == b && n_stb == 0, "plain read");
        open_row = r; open_xfer = xfer;
    endtask
    initial begin
        int n;
        void'($urandom(13));
        repeat (5) @(posedge clock);
        rst <= 0;
        run(1, 0, 0, 5, 2);
        run(1, 0, 0, 5, 3);
        run(0, 0, 1, 5, 2);
        run(1, 0, 0, 5, 1);
        run(0, 1, 0, 9, 4);
        run(0, 1, 0, 9, 32);
        run(1, 1, 0, 9, 6);
        fix_wl = 1;
        run(0, 1, 0, 9, 3);
        fix_wl = 0;
        run(0, 1, 0, 9, 2);
        fix_rl = 0;
        run(1, 0, 0, 9, 2);
        fix_wl = -1;
        fix_rl = -1;
        repeat (8) run($urandom % 2, $urandom % 2, $urandom % 2, $urandom % 3, 1 + $urandom % 8);
        run(0, 0, 0, 7, 32);
        @(posedge clock);
        req_valid <= 1; beats <= 1; src <= 0; dst <= 0; req_write <= 0;
        repeat (3) begin @(negedge clock); chk(req_ready === 1'b0, "full buffer refused"); end
        @(posedge clock);
        req_valid <= 0;
        drain(n);
        chk(n == 32 && rd_valid === 1'b0, "buffer drain");
        print_verdict();
    end
    initial begin
        #900_000;
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
